// ===== verilog/spp_consts.svh
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// Clock and serial timing
`define SPP_MCLK_NS        4
`define SPP_SCK_HALF_NS    20
`define SPP_SCK_HALF_CYC   ((`SPP_SCK_HALF_NS + `SPP_MCLK_NS - 1) / `SPP_MCLK_NS)

// Frame and buffer geometry
`define SPP_WORD_BITS      8
`define SPP_FIFO_DEPTH     16

// Pin slots inside the three-pin group
`define SPP_PIN_MOSI       0
`define SPP_PIN_MISO       1
`define SPP_PIN_SEL        2

// Pull-up control bit positions in the port E control word
`define SPP_PUR_BIT_MOSI   5
`define SPP_PUR_BIT_MISO   6
`define SPP_PUR_BIT_SEL    7

// Reset values
`define SPP_RST_FUNC       3'h0
`define SPP_RST_PULLUP     3'h7
`define SPP_RST_WORD       8'h00

`endif

// ===== verilog/spp_pkg.sv
package spp_pkg;

   // Controller-side shift sequencer
   typedef enum logic [1:0] {
      SPP_IDLE  = 2'b00,
      SPP_SETUP = 2'b01,
      SPP_HIGH  = 2'b10,
      SPP_DONE  = 2'b11
   } spp_state_t;

   // Function of each shared pin
   typedef enum logic {
      SPP_FN_SERIAL  = 1'b0,
      SPP_FN_GENERAL = 1'b1
   } spp_func_t;

endpackage

// ===== verilog/spp_stream_if.sv
`timescale 1ns/10ps

interface spp_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ===== verilog/spp_fifo.sv
`timescale 1ns/10ps

module spp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic  i_mclk,
   input  wire logic  i_arst_n,
   spp_stream_if.snk  s_in,
   spp_stream_if.src  s_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Honest flags straight from the occupancy count
   assign s_in.ready  = (count != (AW+1)'(DEPTH));
   assign s_out.valid = (count != '0);
   assign s_out.data  = mem[rd_idx];
   assign push        = s_in.valid & s_in.ready;
   assign pop         = s_out.valid & s_out.ready;

   // Storage; no reset needed on data
   always_ff @(posedge i_mclk)
   begin
      if (push)
      begin
         mem[wr_idx] <= s_in.data;
      end
   end

   // Pointers wrap at depth
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
         end
         if (pop)
         begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ===== verilog/spp_port.sv
// Overview of operation
// - The controller-out data pin is driven by this port as controller and only received when it is peripheral.
// - As controller the port puts each bit on controller-out half a clock period before the rising sample edge.
// - The controller-in data pin is received as controller and driven only by this port when it is the selected peripheral.
// - As an unselected peripheral the port leaves the controller-in pin undriven.
// - As selected peripheral the port puts each bit on controller-in half a clock period before the controller samples it.
// - As peripheral the port receives a transfer only while its select input is asserted low.
// - After reset all three pins carry their serial function rather than the general port function.
// - Each pin has a pull-up removed when bit 5, 6 or 7 of the port E pull-up control is cleared.
// - In the general port function each pin is separately an input or an output.
// - The serial clock pin is driven as controller and is the data clock input as peripheral.
`include "spp_consts.svh"
`timescale 1ns/10ps

module spp_port (
   input  wire logic       i_mclk,
   input  wire logic       i_arst_n,
   input  wire logic       i_controller_mode,
   input  wire logic [2:0] i_port_e_gpio_select,
   input  wire logic [2:0] i_general_port_e_dir,
   input  wire logic [2:0] i_general_port_e_out,
   output logic      [2:0] o_general_port_e_in,
   input  wire logic [7:0] i_port_e_pullup_control,
   output logic      [2:0] o_pullup_en,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   output logic      [7:0] o_rx_data,
   output logic            o_rx_valid,
   input  wire logic       i_port0_serial_clock,
   output logic            o_port0_serial_clock,
   output logic            o_port0_serial_clock_oe,
   input  wire logic       i_port0_controller_out_data,
   output logic            o_port0_controller_out_data,
   output logic            o_port0_controller_out_data_oe,
   input  wire logic       i_port0_controller_in_data,
   output logic            o_port0_controller_in_data,
   output logic            o_port0_controller_in_data_oe,
   input  wire logic       i_port0_peripheral_select_n,
   output logic            o_port0_peripheral_select_n,
   output logic            o_port0_peripheral_select_n_oe
);
   localparam logic [3:0] HALF_CYC = 4'(`SPP_SCK_HALF_CYC);

   spp_stream_if #(.WIDTH(`SPP_WORD_BITS)) tx_in ();
   spp_stream_if #(.WIDTH(`SPP_WORD_BITS)) tx_out ();

   spp_pkg::spp_state_t state;
   spp_pkg::spp_state_t next_state;

   logic [2:0] pin_in;
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [2:0] func;
   logic [2:0] gen_oe;
   logic [2:0] gen_out;
   logic       serial_mosi;
   logic       serial_miso;
   logic       serial_sel;
   logic [3:0] half_cnt;
   logic [2:0] bit_idx;
   logic [7:0] mst_tx;
   logic [7:0] mst_rx;
   logic       mst_sck;
   logic       mst_take;
   logic [7:0] per_word;
   logic       per_full;
   logic       per_take;
   logic       per_mode;
   logic       sel_active;
   logic       per_clr_n;
   logic [2:0] pos_cnt;
   logic [6:0] rx_sh;
   logic [7:0] rx_hold;
   logic       rx_tgl;
   logic [2:0] neg_cnt;
   logic [7:0] tx_sh;
   logic       ack_tgl;
   logic [2:0] rx_tgl_sync;
   logic [2:0] ack_tgl_sync;
   logic       rx_evt;
   logic       ack_evt;
   logic       per_bit;

   // Pin decode shared by the mux and the serial logic
   function automatic logic is_serial(input logic [2:0] f, input int idx);
      return f[idx] == spp_pkg::SPP_FN_SERIAL;
   endfunction

   // Transmit words queue here; full stalls the user side
   spp_fifo #(
      .WIDTH (`SPP_WORD_BITS),
      .DEPTH (`SPP_FIFO_DEPTH)
   ) u_tx_fifo (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .s_in     (tx_in),
      .s_out    (tx_out)
   );

   assign tx_in.data   = i_tx_data;
   assign tx_in.valid  = i_tx_valid;
   assign o_tx_ready   = tx_in.ready;
   assign tx_out.ready = mst_take | per_take;

   assign pin_in[`SPP_PIN_MOSI] = i_port0_controller_out_data;
   assign pin_in[`SPP_PIN_MISO] = i_port0_controller_in_data;
   assign pin_in[`SPP_PIN_SEL]  = i_port0_peripheral_select_n;

   // Two-stage synchronisers on every shared pin
   generate
      for (genvar g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge i_mclk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               pin_meta[g] <= 1'b1;
               pin_sync[g] <= 1'b1;
            end
            else
            begin
               pin_meta[g] <= pin_in[g];
               pin_sync[g] <= pin_meta[g];
            end
         end
      end
   endgenerate

   assign o_general_port_e_in = pin_sync;

   // Function select and pull-ups; serial function and pull-ups on after reset
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         func        <= `SPP_RST_FUNC;
         o_pullup_en <= `SPP_RST_PULLUP;
      end
      else
      begin
         func                      <= i_port_e_gpio_select;
         o_pullup_en[`SPP_PIN_MOSI] <= i_port_e_pullup_control[`SPP_PUR_BIT_MOSI];
         o_pullup_en[`SPP_PIN_MISO] <= i_port_e_pullup_control[`SPP_PUR_BIT_MISO];
         o_pullup_en[`SPP_PIN_SEL]  <= i_port_e_pullup_control[`SPP_PUR_BIT_SEL];
      end
   end

   assign serial_mosi = is_serial(func, `SPP_PIN_MOSI);
   assign serial_miso = is_serial(func, `SPP_PIN_MISO);
   assign serial_sel  = is_serial(func, `SPP_PIN_SEL);
   assign per_mode    = !i_controller_mode;
   // Select for the controller-in drive seen through the synchroniser, active low
   assign sel_active  = serial_sel & !pin_sync[`SPP_PIN_SEL];

   // General port drive per pin, direction bit per pin
   generate
      for (genvar g = 0; g < 3; g++)
      begin : g_gen
         always_ff @(posedge i_mclk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               gen_oe[g]  <= 1'b0;
               gen_out[g] <= 1'b0;
            end
            else
            begin
               gen_oe[g]  <= !is_serial(func, g) & i_general_port_e_dir[g];
               gen_out[g] <= i_general_port_e_out[g];
            end
         end
      end
   endgenerate

   // Controller sequencer: next state
   always_comb
   begin
      next_state = state;
      case (state)
         spp_pkg::SPP_IDLE:
         begin
            if (i_controller_mode && serial_mosi && tx_out.valid)
            begin
               next_state = spp_pkg::SPP_SETUP;
            end
         end
         spp_pkg::SPP_SETUP:
         begin
            if (half_cnt == HALF_CYC - 4'h1)
            begin
               next_state = spp_pkg::SPP_HIGH;
            end
         end
         spp_pkg::SPP_HIGH:
         begin
            if (half_cnt == HALF_CYC - 4'h1)
            begin
               next_state = (bit_idx == 3'h7) ? spp_pkg::SPP_DONE : spp_pkg::SPP_SETUP;
            end
         end
         default:
         begin
            next_state = spp_pkg::SPP_IDLE;
         end
      endcase
   end

   assign mst_take = (state == spp_pkg::SPP_IDLE) && (next_state == spp_pkg::SPP_SETUP);

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state <= spp_pkg::SPP_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Half-period timer and bit position
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         half_cnt <= 4'h0;
         bit_idx  <= 3'h0;
      end
      else if (state != next_state || state == spp_pkg::SPP_IDLE)
      begin
         half_cnt <= 4'h0;
         if (state == spp_pkg::SPP_HIGH)
         begin
            bit_idx <= bit_idx + 3'h1;
         end
         else if (state == spp_pkg::SPP_IDLE)
         begin
            bit_idx <= 3'h0;
         end
      end
      else
      begin
         half_cnt <= half_cnt + 4'h1;
      end
   end

   // Controller shift: bit out a half period ahead, sample on the rise
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mst_tx  <= `SPP_RST_WORD;
         mst_rx  <= `SPP_RST_WORD;
         mst_sck <= 1'b0;
      end
      else if (mst_take)
      begin
         mst_tx <= tx_out.data;
      end
      else if (state == spp_pkg::SPP_SETUP && next_state == spp_pkg::SPP_HIGH)
      begin
         mst_sck <= 1'b1;
         // Synchronised copy lags two cycles, well inside the low half before the rise
         mst_rx  <= {mst_rx[6:0], pin_sync[`SPP_PIN_MISO]};
      end
      else if (state == spp_pkg::SPP_HIGH && next_state != spp_pkg::SPP_HIGH)
      begin
         mst_sck <= 1'b0;
         mst_tx  <= {mst_tx[6:0], 1'b0};
      end
   end

   // Peripheral word staging; held steady until the link acknowledges
   assign per_take = per_mode && !per_full && tx_out.valid;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         per_word <= `SPP_RST_WORD;
         per_full <= 1'b0;
      end
      else if (per_take)
      begin
         per_word <= tx_out.data;
         per_full <= 1'b1;
      end
      else if (ack_evt)
      begin
         per_full <= 1'b0;
      end
   end

   // Link domain: cleared whenever deselected, so idle clocks do nothing
   assign per_clr_n = i_arst_n & !i_port0_peripheral_select_n;

   // Rising edge: capture controller-out bits
   always_ff @(posedge i_port0_serial_clock or negedge per_clr_n)
   begin
      if (!per_clr_n)
      begin
         pos_cnt <= 3'h0;
         rx_sh   <= 7'h00;
      end
      else
      begin
         pos_cnt <= pos_cnt + 3'h1;
         rx_sh   <= {rx_sh[5:0], i_port0_controller_out_data};
      end
   end

   // Completed byte handed over with a toggle; survives deselect
   always_ff @(posedge i_port0_serial_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_hold <= `SPP_RST_WORD;
         rx_tgl  <= 1'b0;
      end
      else if (!i_port0_peripheral_select_n && pos_cnt == 3'h7)
      begin
         rx_hold <= {rx_sh, i_port0_controller_out_data};
         rx_tgl  <= !rx_tgl;
      end
   end

   // Falling edge: advance controller-in bits
   always_ff @(negedge i_port0_serial_clock or negedge per_clr_n)
   begin
      if (!per_clr_n)
      begin
         neg_cnt <= 3'h0;
         tx_sh   <= `SPP_RST_WORD;
      end
      else
      begin
         neg_cnt <= neg_cnt + 3'h1;
         tx_sh   <= (neg_cnt == 3'h0) ? {per_word[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
      end
   end

   // Word consumed at the last falling edge of each byte
   always_ff @(negedge i_port0_serial_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ack_tgl <= 1'b0;
      end
      else if (!i_port0_peripheral_select_n && neg_cnt == 3'h7)
      begin
         ack_tgl <= !ack_tgl;
      end
   end

   // First bit stands from select onward, before the first rising edge
   assign per_bit = (neg_cnt == 3'h0) ? per_word[7] : tx_sh[7];

   // Toggles back into the main domain; third stage only for edge detect
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_tgl_sync  <= 3'h0;
         ack_tgl_sync <= 3'h0;
      end
      else
      begin
         rx_tgl_sync  <= {rx_tgl_sync[1:0], rx_tgl};
         ack_tgl_sync <= {ack_tgl_sync[1:0], ack_tgl};
      end
   end

   assign rx_evt  = rx_tgl_sync[2] ^ rx_tgl_sync[1];
   assign ack_evt = ack_tgl_sync[2] ^ ack_tgl_sync[1];

   // Received byte out, one-cycle strobe from either role
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_rx_data  <= `SPP_RST_WORD;
         o_rx_valid <= 1'b0;
      end
      else if (state == spp_pkg::SPP_DONE)
      begin
         o_rx_data  <= mst_rx;
         o_rx_valid <= 1'b1;
      end
      else if (per_mode && rx_evt)
      begin
         o_rx_data  <= rx_hold;
         o_rx_valid <= 1'b1;
      end
      else
      begin
         o_rx_valid <= 1'b0;
      end
   end

   // Registered pin drive for controller-out, select and serial clock
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_port0_controller_out_data    <= 1'b0;
         o_port0_controller_out_data_oe <= 1'b0;
         o_port0_peripheral_select_n    <= 1'b1;
         o_port0_peripheral_select_n_oe <= 1'b0;
         o_port0_serial_clock           <= 1'b0;
         o_port0_serial_clock_oe        <= 1'b0;
      end
      else
      begin
         o_port0_controller_out_data    <= serial_mosi ? mst_tx[7] : gen_out[`SPP_PIN_MOSI];
         o_port0_controller_out_data_oe <= serial_mosi ? i_controller_mode : gen_oe[`SPP_PIN_MOSI];
         o_port0_peripheral_select_n    <= gen_out[`SPP_PIN_SEL];
         o_port0_peripheral_select_n_oe <= !serial_sel & gen_oe[`SPP_PIN_SEL];
         o_port0_serial_clock           <= mst_sck;
         o_port0_serial_clock_oe        <= i_controller_mode;
      end
   end

   // Controller-in comes straight from the link domain to keep the half-period lead
   assign o_port0_controller_in_data    = serial_miso ? per_bit : gen_out[`SPP_PIN_MISO];
   assign o_port0_controller_in_data_oe = serial_miso ? (per_mode & sel_active)
                                                      : gen_oe[`SPP_PIN_MISO];
endmodule

// ===== bench/spp_port_properties.sv
`timescale 1ns/10ps
module spp_port_properties (
   input wire logic       i_mclk,
   input wire logic       i_arst_n,
   input wire logic       i_controller_mode,
   input wire logic [2:0] i_port_e_gpio_select,
   input wire logic [2:0] i_general_port_e_dir,
   input wire logic [2:0] i_general_port_e_out,
   input wire logic [7:0] i_port_e_pullup_control,
   input wire logic       i_port0_peripheral_select_n,
   input wire logic [2:0] o_pullup_en,
   input wire logic       o_tx_ready,
   input wire logic       o_rx_valid,
   input wire logic       o_port0_serial_clock,
   input wire logic       o_port0_serial_clock_oe,
   input wire logic       o_port0_controller_out_data,
   input wire logic       o_port0_controller_out_data_oe,
   input wire logic       o_port0_controller_in_data_oe,
   input wire logic       o_port0_peripheral_select_n_oe
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   chk_pullup_copy: assert property ($past(i_arst_n) |-> o_pullup_en == $past(i_port_e_pullup_control[7:5]))
      else $error("pull-up enables do not follow control bits");
   chk_clock_high: assert property ($rose(o_port0_serial_clock) |-> o_port0_serial_clock[*5] ##1 !o_port0_serial_clock)
      else $error("serial clock high phase is not five cycles");
   // Data must already sit on the pin well ahead of the rise
   chk_data_setup: assert property ($rose(o_port0_serial_clock) |->
      o_port0_controller_out_data == $past(o_port0_controller_out_data, 3) ##1 $stable(o_port0_controller_out_data)[*4])
      else $error("controller data moved around the sample edge");
   chk_ctrl_drive: assert property ((i_controller_mode && i_port_e_gpio_select == 3'h0)[*3] |->
      o_port0_controller_out_data_oe && o_port0_serial_clock_oe && !o_port0_controller_in_data_oe)
      else $error("controller pin directions wrong");
   chk_periph_recv: assert property ((!i_controller_mode && i_port_e_gpio_select == 3'h0)[*3] |->
      !o_port0_controller_out_data_oe && !o_port0_serial_clock_oe)
      else $error("peripheral drives an input pin");
   chk_unsel_float: assert property ((!i_controller_mode && i_port0_peripheral_select_n
      && i_port_e_gpio_select[2:1] == 2'h0)[*4] |-> !o_port0_controller_in_data_oe)
      else $error("unselected peripheral drives its output");
   chk_select_input: assert property ((!i_port_e_gpio_select[2])[*3] |-> !o_port0_peripheral_select_n_oe)
      else $error("select pin driven in serial function");
   // Select, then direction, then the pin register: three stages before the pin turns
   chk_general_out: assert property ((i_port_e_gpio_select[0] && i_general_port_e_dir[0]
      && $stable(i_general_port_e_out[0]))[*4] |-> o_port0_controller_out_data_oe
      && o_port0_controller_out_data == i_general_port_e_out[0])
      else $error("general output not on the pin");
   chk_ignore_clock: assert property ((!i_controller_mode && i_port0_peripheral_select_n
      && i_port_e_gpio_select == 3'h0)[*8] |-> !o_rx_valid)
      else $error("word received while deselected");

   cover property (i_controller_mode && o_rx_valid);
   cover property (!i_controller_mode && o_rx_valid);
   cover property (!o_tx_ready);
endmodule

bind spp_port spp_port_properties chk (.*);

// ===== bench/spp_far_end.sv
`timescale 1ns/10ps
module spp_far_end (
   input  wire logic i_ctrl,
   input  wire logic i_cin,
   input  wire logic i_sck,
   input  wire logic i_cout,
   output logic      o_sck,
   output logic      o_cout,
   output logic      o_cin,
   output logic      o_sel_n
);
   logic [7:0] tx;
   logic [7:0] sh;
   logic [7:0] rx_q[$];
   int         nb;

   // Idle: clock held low, deselected
   initial
   begin
      tx = 8'hA5;
      nb = 0;
      o_sck = 1'b0;
      o_cout = 1'b0;
      o_sel_n = 1'b1;
      o_cin = 1'b1;
   end

   // Peripheral role: latch on the rise, whole words only
   always @(posedge i_sck)
   begin
      if (!i_ctrl)
      begin
         sh = {sh[6:0], i_cout};
         nb = nb + 1;
         if (nb == 8)
         begin
            rx_q.push_back(sh);
            nb = 0;
            tx = ~tx;
         end
      end
   end

   // Next bit after the fall, half a period ahead of the rise
   always @(negedge i_sck)
   begin
      if (!i_ctrl)
         o_cin = tx[7 - nb];
   end

   // Controller role: one word at a 160 ns link period, clock still outside
   task automatic frame(input logic [7:0] d, input logic sel);
      #3 o_sel_n = ~sel;
      #80;
      for (int i = 7; i >= 0; i--)
      begin
         o_cout = d[i];
         #80 o_sck = 1'b1;
         sh = {sh[6:0], i_cin};
         #80 o_sck = 1'b0;
      end
      o_cout = ~o_cout;
      #80 o_sel_n = 1'b1;
      if (sel)
         rx_q.push_back(sh);
   endtask
endmodule

// ===== bench/spp_port_bench.sv
`timescale 1ns/10ps
module spp_port_bench;
   logic       i_mclk = 1'b0;
   logic       i_arst_n = 1'b0;
   logic       mode = 1'b0;
   logic [2:0] gsel = 3'h0;
   logic [2:0] gdir = 3'h0;
   logic [2:0] gout = 3'h0;
   logic [7:0] pur = 8'hE0;
   logic [7:0] txd = 8'h00;
   logic       txv = 1'b0;
   logic       txr;
   logic       rxv;
   logic [7:0] rxd;
   logic [2:0] gin;
   logic [2:0] pue;
   logic [2:0] dpin;
   logic [2:0] doe;
   logic [2:0] fpin;
   logic       dsck;
   logic       dsck_oe;
   logic       fsck;
   logic [7:0] rxq[$];
   int         err_count = 0;
   int         n_checks = 0;
   int         n;
   wire  [2:0] foe = {~mode, mode, ~mode};
   wire  [2:0] pin = (doe & dpin) | (~doe & foe & fpin) | (~doe & ~foe); // Pull-ups
   wire        sck = dsck_oe ? dsck : (~mode ? fsck : 1'b0); // Pulled low

   always #2 i_mclk = ~i_mclk;

   // Collect every received word
   always @(posedge i_mclk)
   begin
      if (rxv === 1'b1)
         rxq.push_back(rxd);
   end

   spp_port dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_controller_mode(mode),
      .i_port_e_gpio_select(gsel), .i_general_port_e_dir(gdir), .i_general_port_e_out(gout),
      .o_general_port_e_in(gin), .i_port_e_pullup_control(pur), .o_pullup_en(pue),
      .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr), .o_rx_data(rxd), .o_rx_valid(rxv),
      .i_port0_serial_clock(sck), .o_port0_serial_clock(dsck), .o_port0_serial_clock_oe(dsck_oe),
      .i_port0_controller_out_data(pin[0]), .o_port0_controller_out_data(dpin[0]),
      .o_port0_controller_out_data_oe(doe[0]), .i_port0_controller_in_data(pin[1]),
      .o_port0_controller_in_data(dpin[1]), .o_port0_controller_in_data_oe(doe[1]),
      .i_port0_peripheral_select_n(pin[2]), .o_port0_peripheral_select_n(dpin[2]),
      .o_port0_peripheral_select_n_oe(doe[2]));

   spp_far_end far (.i_ctrl(~mode), .i_cin(pin[1]), .i_sck(sck), .i_cout(pin[0]), .o_sck(fsck),
      .o_cout(fpin[0]), .o_cin(fpin[1]), .o_sel_n(fpin[2]));

   task automatic cyc(input int k);
      repeat (k) @(negedge i_mclk);
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Each pull-up enable drops alone; bits 0..4 are don't-care
   task automatic t_pullups;
      for (int i = 0; i < 3; i++)
      begin
         pur = 8'hFF ^ (8'h20 << i);
         cyc(3);
         check("pull-up enable", 8'h07 ^ (8'h01 << i), 8'(pue));
      end
      pur = 8'hE0;
      $display("test pull-ups done");
   endtask

   // Each pin alone as general output then input
   task automatic t_general;
      mode = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         gsel = 3'h1 << (i % 3);
         gdir = (i < 3) ? gsel : 3'h0;
         cyc(5);
         check("general oe", 8'(gdir), 8'(doe & gsel));
         check("general in", 8'(~gdir & gsel), 8'(gin & gsel));
      end
      gsel = 3'h0;
      gdir = 3'h0;
      mode = 1'b0;
      cyc(5);
      $display("test general pins done");
   endtask

   // Selected word exchange, then a frame with select high
   task automatic t_periph;
      txv = 1'b1;
      txd = 8'h96;
      cyc(1);
      txv = 1'b0;
      cyc(10);
      far.frame(8'h69, 1'b1);
      cyc(20);
      check("peripheral rx", 8'h69, rxq[0]);
      check("far rx", 8'h96, far.rx_q[$]);
      check("ctrl-in released", 8'h00, 8'(doe[1]));
      far.frame(8'hFF, 1'b0);
      cyc(20);
      check("ignored frame", 8'h01, 8'(rxq.size()));
      $display("test peripheral done");
   endtask

   // Fill while only the peripheral staging register drains one word, refusals included
   task automatic t_fill;
      n = 0;
      for (int i = 0; i < 40; i++)
      begin
         @(negedge i_mclk);
         txd = 8'h10 + 8'(n);
         txv = 1'b1;
         n += int'(txr === 1'b1);
      end
      cyc(1); // Last offer must meet a rising edge before the strobe drops
      txv = 1'b0;
      check("ready when full", 8'h00, 8'(txr));
      check("words held", 8'h01, 8'(n >= 16 && n <= 17));
      $display("test fill done");
   endtask

   // Controller drains the buffer to the far peripheral
   task automatic t_ctrl;
      int i;
      int base;
      base = far.rx_q.size();
      mode = 1'b1;
      for (i = 0; i < 3000 && far.rx_q.size() < base + 16; i++)
         cyc(1);
      if (i == 3000)
      begin
         err_count++;
         results();
      end
      cyc(300);
      check("ready after drain", 8'h01, 8'(txr));
      check("last word out", 8'h10 + 8'(n - 1), far.rx_q[$]);
      check("first word in", 8'hA5, rxq[1]);
      check("second word in", 8'h5A, rxq[2]);
      $display("test controller done");
   endtask

   initial
   begin
      cyc(3);
      check("oe in reset", 8'h00, 8'(doe));
      check("pull-ups in reset", 8'h07, 8'(pue));
      i_arst_n = 1'b1;
      cyc(4);
      check("oe after reset", 8'h00, 8'(doe));
      $display("test reset done");
      t_pullups();
      t_general();
      t_periph();
      t_fill();
      t_ctrl();
      results();
   end
endmodule
